// ==== rtl/hpo_pkg.sv ====
// constants for the handshake port output and bit i/o block
// What this block does
// - submode 01 gives double-buffered eight-bit output through the output latches
// - strobe edge takes data; next buffered byte then moves to the output latch
// - status bit 0 clear: strobe flag set while a latch can accept data
// - status bit 0 set: strobe flag set only while both latches are empty
// - handshake code 0XX: handshake pin edge sets its sticky flag
// - sticky flag clears on reset, write of one, or enable clear
// - codes 100 and 101 drive the pin negated or asserted, flag clear
// - interlocked code 110 asserts the pin two cycles after data loads
// - pin stays asserted until strobe edge, negates asynchronously, next data loads
// - strobe ignored until the handshake pin asserts; pulsed code stays armed after the pulse; flag clear in both protocols
// - pulsed code 111 asserts at most four cycles; strobe shortens it
// - enable clear holds the handshake pin negated in both protocols
// - input-direction pins still get double-buffered data but no driver
// - control bit 1 gates strobe interrupt and dma request
// - control bit 2 gates the handshake flag interrupt
// - bit i/o writes single buffered; direction one drives, zero only latches
// - bit i/o read gives pin for inputs, latch for outputs
// - bit i/o strobe only sets its sticky flag, no data function
// - bit i/o codes 1X0 and 1X1 give constant pin, flag clear
// - port b control has the same fields as port a
// - control registers read and write freely, reads have no effect
`default_nettype none
package hpo_pkg;
    localparam int PORTS = 2;
    localparam int DW = 8;
    localparam int AW = 3;
    // register offsets
    localparam logic [AW-1:0] OFS_CTRL_A = 3'h0;
    localparam logic [AW-1:0] OFS_CTRL_B = 3'h1;
    localparam logic [AW-1:0] OFS_DIR_A = 3'h2;
    localparam logic [AW-1:0] OFS_DIR_B = 3'h3;
    localparam logic [AW-1:0] OFS_DATA_A = 3'h4;
    localparam logic [AW-1:0] OFS_DATA_B = 3'h5;
    localparam logic [AW-1:0] OFS_ENABLE = 3'h6;
    localparam logic [AW-1:0] OFS_FLAGS = 3'h7;
    // control register fields
    localparam int F_SUB_HI = 7;
    localparam int F_SUB_LO = 6;
    localparam int F_HS_HI = 5;
    localparam int F_HS_MID = 4;
    localparam int F_HS_LO = 3;
    localparam int F_HS_IE = 2;
    localparam int F_SVC_EN = 1;
    localparam int F_STAT_CTL = 0;
    localparam logic [1:0] SUB_OUT = 2'h1;
    // flag register layout, per port
    localparam int FLG_STB = 0;
    localparam int FLG_HS = 1;
    localparam int FLG_STRIDE = 2;
    // handshake timing in clock cycles
    localparam logic [1:0] HS_DELAY_CYC = 2'h2;
    localparam logic [2:0] HS_PULSE_CYC = 3'h4;
endpackage
`default_nettype wire

// ==== rtl/hpo_port.sv ====
// two eight-bit handshake ports: double-buffered output and bit i/o
//
// Added by the designer: the address-and-strobe port and the register addresses.
`default_nettype none
module hpo_port (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire logic [hpo_pkg::AW-1:0] reg_addr,
    input wire logic [hpo_pkg::DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [hpo_pkg::DW-1:0] reg_rdata,
    // port a pins
    input wire logic [hpo_pkg::DW-1:0] port_a_pin_in,
    output logic [hpo_pkg::DW-1:0] port_a_pin_out,
    output logic [hpo_pkg::DW-1:0] port_a_pin_oe,
    input wire logic port_a_strobe_in,
    input wire logic port_a_handshake_pin_in,
    output logic port_a_handshake_pin_out,
    output logic port_a_handshake_pin_oe,
    // port a requests
    output logic port_a_svc_req,
    output logic port_a_dma_req,
    output logic port_a_hs_req,
    // port b pins
    input wire logic [hpo_pkg::DW-1:0] port_b_pin_in,
    output logic [hpo_pkg::DW-1:0] port_b_pin_out,
    output logic [hpo_pkg::DW-1:0] port_b_pin_oe,
    input wire logic port_b_strobe_in,
    input wire logic port_b_handshake_pin_in,
    output logic port_b_handshake_pin_out,
    output logic port_b_handshake_pin_oe,
    // port b requests
    output logic port_b_svc_req,
    output logic port_b_dma_req,
    output logic port_b_hs_req
);
    localparam int NP = hpo_pkg::PORTS;
    localparam int DW = hpo_pkg::DW;
    localparam int AW = hpo_pkg::AW;

    typedef struct packed {
        logic [NP-1:0][DW-1:0] ctrl;
        logic [NP-1:0][DW-1:0] dir;
        logic [NP-1:0][DW-1:0] iol;
        logic [NP-1:0][DW-1:0] fol;
        logic [NP-1:0][DW-1:0] pin_s1;
        logic [NP-1:0][DW-1:0] pin_s2;
        logic [NP-1:0] iol_full;
        logic [NP-1:0] fol_full;
        logic [NP-1:0] en;
        logic [NP-1:0] sflag;
        logic [NP-1:0] hflag;
        logic [NP-1:0][2:0] stb_s;
        logic [NP-1:0][2:0] hsi_s;
        logic [NP-1:0][1:0] dly;
        logic [NP-1:0][2:0] pcnt;
        logic [NP-1:0] hs_on;
        logic [NP-1:0] armed;
        logic [DW-1:0] rdata;
    } hpo_state_t;

    hpo_state_t st_ff;
    hpo_state_t nxt_st;
    logic [1:0] rst_sync_ff;
    logic rst_sync_n;
    logic [NP-1:0] stb_raw;
    logic [NP-1:0] hsi_raw;
    logic [NP-1:0][DW-1:0] pin_raw;
    logic [NP-1:0] stb_stat;
    logic [NP-1:0] svc;
    logic [NP-1:0] hsr;
    logic [NP-1:0] hso;
    logic [NP-1:0] hsoe;

    function automatic logic is_out_sub(input logic [DW-1:0] c);
        return c[hpo_pkg::F_SUB_HI:hpo_pkg::F_SUB_LO] == hpo_pkg::SUB_OUT;
    endfunction

    function automatic logic is_proto(input logic [DW-1:0] c);
        return is_out_sub(c) && c[hpo_pkg::F_HS_HI] && c[hpo_pkg::F_HS_MID];
    endfunction

    function automatic logic sel(input logic [AW-1:0] a, input logic [AW-1:0] base,
                                 input int i);
        return a == AW'(int'(base) + i);
    endfunction

    // reset release through two flops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_ff <= '0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_sync_ff[1];

    assign stb_raw = {port_b_strobe_in, port_a_strobe_in};
    assign hsi_raw = {port_b_handshake_pin_in, port_a_handshake_pin_in};
    assign pin_raw = {port_b_pin_in, port_a_pin_in};

    always_comb begin
        logic stb_edge;
        logic hs_edge;
        logic accept;
        logic move;
        logic wr_data;
        logic clr_w;
        logic [DW-1:0] rd;
        logic [DW-1:0] flags;
        stb_edge = 1'b0;
        hs_edge = 1'b0;
        accept = 1'b0;
        move = 1'b0;
        wr_data = 1'b0;
        clr_w = reg_wr && reg_addr == hpo_pkg::OFS_FLAGS;
        rd = '0;
        flags = '0;
        nxt_st = st_ff;
        nxt_st.rdata = '0;
        nxt_st.pin_s1 = pin_raw;
        nxt_st.pin_s2 = st_ff.pin_s1;
        for (int i = 0; i < NP; i++) begin
            nxt_st.stb_s[i] = {st_ff.stb_s[i][1:0], stb_raw[i]};
            nxt_st.hsi_s[i] = {st_ff.hsi_s[i][1:0], hsi_raw[i]};
            stb_edge = st_ff.stb_s[i][1] && !st_ff.stb_s[i][2];
            hs_edge = st_ff.hsi_s[i][1] && !st_ff.hsi_s[i][2];
            if (reg_wr && sel(reg_addr, hpo_pkg::OFS_CTRL_A, i)) begin
                nxt_st.ctrl[i] = reg_wdata;
            end
            if (reg_wr && sel(reg_addr, hpo_pkg::OFS_DIR_A, i)) begin
                nxt_st.dir[i] = reg_wdata;
            end
            if (reg_wr && reg_addr == hpo_pkg::OFS_ENABLE) begin
                nxt_st.en[i] = reg_wdata[i];
            end
            wr_data = reg_wr && sel(reg_addr, hpo_pkg::OFS_DATA_A, i);
            if (is_out_sub(st_ff.ctrl[i])) begin
                nxt_st.sflag[i] = 1'b0;
                if (st_ff.dly[i] != 2'h0) begin
                    nxt_st.dly[i] = 2'(st_ff.dly[i] - 2'h1);
                end
                if (st_ff.dly[i] == 2'h1) begin
                    nxt_st.hs_on[i] = 1'b1;
                    nxt_st.armed[i] = 1'b1;
                    nxt_st.pcnt[i] = hpo_pkg::HS_PULSE_CYC;
                end
                // pulse ends but the strobe stays armed until it comes
                if (st_ff.hs_on[i] && st_ff.ctrl[i][hpo_pkg::F_HS_LO]) begin
                    nxt_st.pcnt[i] = 3'(st_ff.pcnt[i] - 3'h1);
                    if (st_ff.pcnt[i] == 3'h1) begin
                        nxt_st.hs_on[i] = 1'b0;
                    end
                end
                if (is_proto(st_ff.ctrl[i])) begin
                    accept = stb_edge && st_ff.armed[i] && st_ff.en[i];
                end else begin
                    accept = stb_edge && st_ff.fol_full[i];
                end
                if (accept) begin
                    nxt_st.fol_full[i] = 1'b0;
                    nxt_st.hs_on[i] = 1'b0;
                    nxt_st.armed[i] = 1'b0;
                end
                move = st_ff.iol_full[i] && (!st_ff.fol_full[i] || accept);
                if (move) begin
                    nxt_st.fol[i] = st_ff.iol[i];
                    nxt_st.fol_full[i] = 1'b1;
                    nxt_st.iol_full[i] = 1'b0;
                    nxt_st.dly[i] = hpo_pkg::HS_DELAY_CYC;
                end
                // a write into two full latches is dropped unless a strobe is accepted in the same cycle
                if (wr_data && (!st_ff.iol_full[i] || move)) begin
                    nxt_st.iol[i] = reg_wdata;
                    nxt_st.iol_full[i] = 1'b1;
                end
                if (!is_proto(st_ff.ctrl[i])) begin
                    nxt_st.hs_on[i] = 1'b0;
                    nxt_st.armed[i] = 1'b0;
                end
            end else begin
                if (wr_data) begin
                    nxt_st.fol[i] = reg_wdata;
                end
                nxt_st.iol_full[i] = 1'b0;
                nxt_st.fol_full[i] = 1'b0;
                nxt_st.hs_on[i] = 1'b0;
                nxt_st.armed[i] = 1'b0;
                nxt_st.dly[i] = 2'h0;
                if ((clr_w && reg_wdata[hpo_pkg::FLG_STRIDE * i + hpo_pkg::FLG_STB])
                        || !st_ff.en[i]) begin
                    nxt_st.sflag[i] = 1'b0;
                end
                if (stb_edge && st_ff.en[i]) begin
                    nxt_st.sflag[i] = 1'b1;
                end
            end
            // set after clear, so an edge in the clearing cycle survives
            if (!st_ff.ctrl[i][hpo_pkg::F_HS_HI]) begin
                if ((clr_w && reg_wdata[hpo_pkg::FLG_STRIDE * i + hpo_pkg::FLG_HS])
                        || !st_ff.en[i]) begin
                    nxt_st.hflag[i] = 1'b0;
                end
                if (hs_edge && st_ff.en[i]) begin
                    nxt_st.hflag[i] = 1'b1;
                end
            end else begin
                nxt_st.hflag[i] = 1'b0;
            end
            flags[hpo_pkg::FLG_STRIDE * i + hpo_pkg::FLG_STB] = stb_stat[i];
            flags[hpo_pkg::FLG_STRIDE * i + hpo_pkg::FLG_HS] = st_ff.hflag[i];
            if (sel(reg_addr, hpo_pkg::OFS_CTRL_A, i)) begin
                rd = st_ff.ctrl[i];
            end
            if (sel(reg_addr, hpo_pkg::OFS_DIR_A, i)) begin
                rd = st_ff.dir[i];
            end
            if (sel(reg_addr, hpo_pkg::OFS_DATA_A, i)) begin
                rd = (st_ff.dir[i] & st_ff.fol[i]) | (~st_ff.dir[i] & st_ff.pin_s2[i]);
            end
        end
        if (reg_addr == hpo_pkg::OFS_ENABLE) begin
            rd = DW'(st_ff.en);
        end
        if (reg_addr == hpo_pkg::OFS_FLAGS) begin
            rd = flags;
        end
        if (reg_rd) begin
            nxt_st.rdata = rd;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    for (genvar g = 0; g < NP; g++) begin : g_port
        logic [2:0] hc;
        assign hc = st_ff.ctrl[g][hpo_pkg::F_HS_HI:hpo_pkg::F_HS_LO];
        assign stb_stat[g] = !is_out_sub(st_ff.ctrl[g]) ? st_ff.sflag[g] :
            st_ff.ctrl[g][hpo_pkg::F_STAT_CTL] ?
            !(st_ff.iol_full[g] || st_ff.fol_full[g]) :
            !(st_ff.iol_full[g] && st_ff.fol_full[g]);
        assign svc[g] = stb_stat[g] && st_ff.ctrl[g][hpo_pkg::F_SVC_EN];
        assign hsr[g] = st_ff.hflag[g] && st_ff.ctrl[g][hpo_pkg::F_HS_IE];
        // raw strobe negates at once; the synced path updates state later
        assign hso[g] = is_proto(st_ff.ctrl[g]) ?
            (st_ff.hs_on[g] && st_ff.en[g] && !stb_raw[g]) :
            (hc[0] && (st_ff.ctrl[g][hpo_pkg::F_SUB_HI] || !hc[1]));
        assign hsoe[g] = hc[2];
    end

    assign reg_rdata = st_ff.rdata;
    assign port_a_pin_out = st_ff.fol[0];
    assign port_a_pin_oe = st_ff.dir[0];
    assign port_b_pin_out = st_ff.fol[1];
    assign port_b_pin_oe = st_ff.dir[1];
    assign port_a_handshake_pin_out = hso[0];
    assign port_a_handshake_pin_oe = hsoe[0];
    assign port_b_handshake_pin_out = hso[1];
    assign port_b_handshake_pin_oe = hsoe[1];
    assign port_a_svc_req = svc[0];
    assign port_a_dma_req = svc[0];
    assign port_a_hs_req = hsr[0];
    assign port_b_svc_req = svc[1];
    assign port_b_dma_req = svc[1];
    assign port_b_hs_req = hsr[1];
endmodule
`default_nettype wire

// ==== testbench/hpo_port_sva.sv ====
// concurrent checks on the handshake port block ports
`default_nettype none
module hpo_port_chk (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire logic [hpo_pkg::AW-1:0] reg_addr,
    input wire logic [hpo_pkg::DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [hpo_pkg::DW-1:0] reg_rdata,
    // port a handshake and requests
    input wire logic port_a_strobe_in,
    input wire logic port_a_handshake_pin_out,
    input wire logic port_a_handshake_pin_oe,
    input wire logic port_a_svc_req,
    input wire logic port_a_dma_req,
    input wire logic port_a_hs_req,
    // port b requests
    input wire logic port_b_svc_req,
    input wire logic port_b_dma_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ctl_ff;
    logic [1:0] en_ff;
    logic [2:0] hi_ff;
    logic hsk;
    // shadows load on the same edge as the real registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctl_ff <= 8'h00;
            en_ff <= 2'h0;
            hi_ff <= 3'h0;
        end else begin
            if (reg_wr && reg_addr == hpo_pkg::OFS_CTRL_A) ctl_ff <= reg_wdata;
            if (reg_wr && reg_addr == hpo_pkg::OFS_ENABLE) en_ff <= reg_wdata[1:0];
            hi_ff <= !port_a_handshake_pin_out ? 3'h0 : (hi_ff == 3'h7) ? hi_ff : hi_ff + 3'h1;
        end
    end
    assign hsk = ctl_ff[7:6] == 2'h1 && ctl_ff[5:4] == 2'h3;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_stb_hs; hsk && port_a_strobe_in; endsequence
    sequence s_pulse_hi; hsk && ctl_ff[3] && port_a_handshake_pin_out; endsequence
    property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_dma_a; port_a_dma_req == port_a_svc_req; endproperty
    a_dma_a: assert property (p_dma_a) else $error("dma request differs");
    property p_svc_gate; !ctl_ff[1] |-> !port_a_svc_req; endproperty
    a_svc_gate: assert property (p_svc_gate) else $error("service request ungated");
    property p_hs_oe; port_a_handshake_pin_oe == ctl_ff[5]; endproperty
    a_hs_oe: assert property (p_hs_oe) else $error("handshake direction wrong");
    property p_neg; ctl_ff[5:3] == 3'h4 |-> !port_a_handshake_pin_out; endproperty
    a_neg: assert property (p_neg) else $error("constant low pin high");
    property p_pos; ctl_ff[5:3] == 3'h5 |-> port_a_handshake_pin_out; endproperty
    a_pos: assert property (p_pos) else $error("constant high pin low");
    property p_hs_irq;
        !ctl_ff[2] || (ctl_ff[5] && $past(ctl_ff[5])) |-> !port_a_hs_req;
    endproperty
    a_hs_irq: assert property (p_hs_irq) else $error("handshake request not clear");
    property p_drop; s_stb_hs |-> !port_a_handshake_pin_out; endproperty
    a_drop: assert property (p_drop) else $error("pin high during strobe");
    property p_en; hsk && !en_ff[0] |-> !port_a_handshake_pin_out; endproperty
    a_en: assert property (p_en) else $error("pin high while disabled");
    property p_pulse; s_pulse_hi |-> hi_ff < 3'h4; endproperty
    a_pulse: assert property (p_pulse) else $error("pulse too long");
    property p_dma_b; port_b_dma_req == port_b_svc_req; endproperty
    a_dma_b: assert property (p_dma_b) else $error("port b dma request differs");
endmodule
bind hpo_port hpo_port_chk u_chk (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .port_a_strobe_in(port_a_strobe_in), .port_a_handshake_pin_out(port_a_handshake_pin_out),
    .port_a_handshake_pin_oe(port_a_handshake_pin_oe), .port_a_svc_req(port_a_svc_req),
    .port_a_dma_req(port_a_dma_req), .port_a_hs_req(port_a_hs_req),
    .port_b_svc_req(port_b_svc_req), .port_b_dma_req(port_b_dma_req));
`default_nettype wire

// ==== testbench/hpo_periph.sv ====
// peripheral that takes bytes with the strobe pin
`default_nettype none
module hpo_periph (
    // clock
    input wire logic clock,
    // link pins
    input wire logic hs_out,
    input wire logic [7:0] data,
    output logic strobe,
    // bench control and capture
    input wire logic go,
    input wire logic [3:0] dly,
    output logic [7:0] got,
    output logic [7:0] cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic seen = 1'b0;
    // remembers a pulse even when it ends before the peripheral is ready
    always @(posedge clock) begin
        if (hs_out) begin
            seen <= 1'b1;
        end else if (strobe) begin
            seen <= 1'b0;
        end
    end
    initial begin
        strobe = 1'b0;
        got = 8'h00;
        cnt = 8'h00;
        forever begin
            @(posedge clock);
            if (go && seen) begin
                repeat (dly) @(posedge clock);
                got <= data;
                cnt <= cnt + 8'h01;
                strobe <= 1'b1;
                // held long enough for the synchroniser to see it
                repeat (4) @(posedge clock);
                strobe <= 1'b0;
                repeat (3) @(posedge clock);
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench/hpo_port_tb_top.sv ====
// self-checking bench for the handshake port block
`default_nettype none
module hpo_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic a_hs_in = 1'b0;
    logic b_stb = 1'b0;
    logic b_hs_in = 1'b0;
    logic take = 1'b0;
    logic [3:0] dly = 4'h0;
    logic [7:0] reg_rdata, pa_out, pa_oe, pb_out, pb_oe, pa_in, pb_in, got, cnt;
    logic a_stb, a_hs, a_hs_oe, b_hs, b_hs_oe, a_svc, a_dma, a_hsq, b_svc, b_dma, b_hsq;
    logic [2:0] t_adr [4] = '{hpo_pkg::OFS_CTRL_B, hpo_pkg::OFS_CTRL_B,
        hpo_pkg::OFS_CTRL_A, hpo_pkg::OFS_CTRL_A};
    logic [7:0] t_val [4] = '{8'ha8, 8'hb0, 8'h60, 8'h68};
    logic [7:0] t_exp [4] = '{8'h03, 8'h02, 8'h02, 8'h03};
    int err_total = 0;
    int comparisons = 0;
    int n;
    always #2 clock = ~clock;
    // undriven pins read a fixed external pattern
    assign pa_in = (pa_out & pa_oe) | (~pa_oe & 8'h5a);
    assign pb_in = (pb_out & pb_oe) | (~pb_oe & 8'ha5);
    hpo_port dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_a_pin_in(pa_in),
        .port_a_pin_out(pa_out), .port_a_pin_oe(pa_oe), .port_a_strobe_in(a_stb),
        .port_a_handshake_pin_in(a_hs_in), .port_a_handshake_pin_out(a_hs),
        .port_a_handshake_pin_oe(a_hs_oe), .port_a_svc_req(a_svc), .port_a_dma_req(a_dma),
        .port_a_hs_req(a_hsq), .port_b_pin_in(pb_in), .port_b_pin_out(pb_out),
        .port_b_pin_oe(pb_oe), .port_b_strobe_in(b_stb), .port_b_handshake_pin_in(b_hs_in),
        .port_b_handshake_pin_out(b_hs), .port_b_handshake_pin_oe(b_hs_oe),
        .port_b_svc_req(b_svc), .port_b_dma_req(b_dma), .port_b_hs_req(b_hsq));
    hpo_periph u_periph (.clock(clock), .hs_out(a_hs), .data(pa_in), .strobe(a_stb),
        .go(take), .dly(dly), .got(got), .cnt(cnt));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk("rdata", reg_rdata, exp);
    endtask
    task automatic pulse(input logic sel);
        @(posedge clock);
        if (sel) a_hs_in <= 1'b1;
        else {b_stb, b_hs_in} <= 2'h3;
        repeat (4) @(posedge clock);
        a_hs_in <= 1'b0;
        {b_stb, b_hs_in} <= 2'h0;
        repeat (4) @(posedge clock);
    endtask
    task automatic wcnt(input logic [7:0] c, input logic [7:0] d);
        for (n = 0; cnt !== c && n < 200; n++) @(posedge clock);
        chk("taken byte", got, d);
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        summarize;
    end
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd(hpo_pkg::OFS_CTRL_A, 8'h00);
        wr(hpo_pkg::OFS_CTRL_B, 8'h5a);
        rd(hpo_pkg::OFS_CTRL_B, 8'h5a);
        rd(hpo_pkg::OFS_CTRL_B, 8'h5a);
        $display("test registers done");
        wr(hpo_pkg::OFS_ENABLE, 8'h03);
        wr(hpo_pkg::OFS_CTRL_B, 8'h80);
        wr(hpo_pkg::OFS_DIR_B, 8'hf0);
        wr(hpo_pkg::OFS_DATA_B, 8'h3c);
        rd(hpo_pkg::OFS_DATA_B, 8'h35);
        chk("b out", pb_out, 8'h3c);
        chk("b drive", pb_oe, 8'hf0);
        pulse(1'b0);
        rd(hpo_pkg::OFS_FLAGS, 8'h0c);
        chk("b svc", {b_hsq, b_dma, b_svc}, 8'h00);
        wr(hpo_pkg::OFS_CTRL_B, 8'h86);
        #1 chk("b svc", {b_hsq, b_dma, b_svc}, 8'h07);
        wr(hpo_pkg::OFS_FLAGS, 8'h04);
        rd(hpo_pkg::OFS_FLAGS, 8'h08);
        wr(hpo_pkg::OFS_FLAGS, 8'h08);
        rd(hpo_pkg::OFS_FLAGS, 8'h00);
        pulse(1'b0);
        wr(hpo_pkg::OFS_ENABLE, 8'h01);
        rd(hpo_pkg::OFS_FLAGS, 8'h00);
        wr(hpo_pkg::OFS_CTRL_A, 8'h84);
        pulse(1'b1);
        rd(hpo_pkg::OFS_FLAGS, 8'h02);
        chk("a hs req", {a_hs_oe, a_hsq}, 8'h01);
        wr(hpo_pkg::OFS_FLAGS, 8'h02);
        rd(hpo_pkg::OFS_FLAGS, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(t_adr[i], t_val[i]);
            #1 chk("hs pin", i < 2 ? {b_hs_oe, b_hs} : {a_hs_oe, a_hs}, t_exp[i]);
        end
        $display("test bit io done");
        wr(hpo_pkg::OFS_ENABLE, 8'h03);
        wr(hpo_pkg::OFS_DIR_A, 8'h0f);
        wr(hpo_pkg::OFS_CTRL_A, 8'h72);
        wr(hpo_pkg::OFS_DATA_A, 8'h11);
        for (n = 0; pa_out !== 8'h11 && n < 20; n++) @(posedge clock) #1;
        for (n = 0; a_hs !== 1'b1 && n < 20; n++) @(posedge clock) #1;
        chk("hs delay", n[7:0], {6'h00, hpo_pkg::HS_DELAY_CYC});
        wr(hpo_pkg::OFS_DATA_A, 8'h22);
        wr(hpo_pkg::OFS_DATA_A, 8'h33);
        rd(hpo_pkg::OFS_FLAGS, 8'h00);
        chk("a out", pa_out, 8'h11);
        chk("a drive", pa_oe, 8'h0f);
        wr(hpo_pkg::OFS_ENABLE, 8'h02);
        #1 chk("hs gated", a_hs, 1'b0);
        wr(hpo_pkg::OFS_ENABLE, 8'h03);
        #1 chk("hs held", a_hs, 1'b1);
        take <= 1'b1;
        wcnt(8'h01, 8'h51);
        wcnt(8'h02, 8'h52);
        repeat (40) @(posedge clock);
        chk("full drop", cnt, 8'h02);
        rd(hpo_pkg::OFS_FLAGS, 8'h01);
        chk("a svc", {a_dma, a_svc}, 8'h03);
        wr(hpo_pkg::OFS_CTRL_A, 8'h73);
        rd(hpo_pkg::OFS_FLAGS, 8'h01);
        take <= 1'b0;
        wr(hpo_pkg::OFS_DATA_A, 8'h44);
        rd(hpo_pkg::OFS_FLAGS, 8'h00);
        take <= 1'b1;
        wcnt(8'h03, 8'h54);
        take <= 1'b0;
        repeat (10) @(posedge clock);
        $display("test interlocked done");
        wr(hpo_pkg::OFS_CTRL_A, 8'h7a);
        wr(hpo_pkg::OFS_DATA_A, 8'h66);
        for (n = 0; a_hs !== 1'b1 && n < 20; n++) @(posedge clock) #1;
        for (n = 0; a_hs === 1'b1 && n < 20; n++) @(posedge clock) #1;
        chk("pulse", n[7:0], {5'h00, hpo_pkg::HS_PULSE_CYC});
        dly <= 4'h6;
        take <= 1'b1;
        wcnt(8'h04, 8'h56);
        $display("test pulsed done");
        summarize;
    end
endmodule
`default_nettype wire
